// ---- core/pirq_defines.vh ----
// constants for the prioritised interrupt controller
`ifndef PIRQ_DEFINES_VH
`define PIRQ_DEFINES_VH

`define PIRQ_AW           8
`define PIRQ_DW           8
`define PIRQ_VW           12

`define PIRQ_OFF_OPTION   8'hC8
`define PIRQ_OFF_EVT_A    8'hF0
`define PIRQ_OFF_EVT_B    8'hF1
`define PIRQ_OFF_STATUS   8'hF2

`define PIRQ_OPTION_RST   8'h00
`define PIRQ_BIT_LES      6
`define PIRQ_BIT_ESB      5
`define PIRQ_BIT_GEN      4

`define PIRQ_VEC_NMI      12'hFFC
`define PIRQ_VEC_SRC1     12'hFF6
`define PIRQ_VEC_SRC2     12'hFF4
`define PIRQ_VEC_SRC3     12'hFF2
`define PIRQ_VEC_SRC4     12'hFF0

`define PIRQ_MODE_NORM    2'h0
`define PIRQ_MODE_IRQ     2'h1
`define PIRQ_MODE_NMI     2'h2

`define PIRQ_LDI_WIN      2'h3
`define PIRQ_NEVT         4

`endif

// ---- core/pirq_sync.v ----
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module pirq_sync #(
	parameter W   = 1,
	parameter RST = 1'b1
) (
	input  wire         clk,
	input  wire         resetn,
	input  wire [W-1:0] din,
	output wire [W-1:0] dout
);

	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= {W{RST}};
			sync_r <= {W{RST}};
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	assign dout = sync_r;

endmodule

`default_nettype wire

// ---- core/pirq_edge_latch.v ----
// edge capture latch or pass-through level sense for one source line
`timescale 1ns/100ps
`default_nettype none

module pirq_edge_latch (
	input  wire clk,
	input  wire resetn,
	input  wire line,
	input  wire level_mode,
	input  wire rise_sel,
	input  wire clr,
	output wire req
);

	reg prev_r;
	reg latch_r;
	reg latch_nxt;
	wire edge_hit;

	assign edge_hit = rise_sel ? (line & ~prev_r) : (~line & prev_r);

	// [R11] single stored edge
	always @* begin
		latch_nxt = latch_r;
		if (clr)
			latch_nxt = 1'b0;
		if (edge_hit)
			latch_nxt = 1'b1;
		// [R12] level mode stores nothing
		if (level_mode)
			latch_nxt = 1'b0;
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_r  <= 1'b1;
			latch_r <= 1'b0;
		end else begin
			prev_r  <= line;
			latch_r <= latch_nxt;
		end
	end

	// [R08] low level requests in level mode
	assign req = level_mode ? ~line : latch_r;

endmodule

`default_nettype wire

// ---- core/pirq_ctrl.v ----
// interrupt controller: sensing, priority, vectoring and flag-set switching
// Operation
// [R01] NMI plus four maskable, own vectors
// [R02] sources 3,4 vectors; PC loads vector
// [R03] NMI preempts; maskables never nest
// [R04] maskable priority: 1 highest, 4 lowest
// [R05] global enable gates maskables only
// [R06] NMI wakes only when enable set
// [R07] NMI latched, cleared at service start
// [R08] source 1 level or falling edge
// [R09] source 2 edge, polarity selectable
// [R10] sources 3 and 4 level only
// [R11] edge latch holds one request
// [R12] level mode: line low when sampled
// [R13] sample at instruction end, replace next
// [R14] three carry/zero pairs, auto switched
// [R15] swap flags, push, inhibit, clear, vector
// [R16] ldi zero window skips flag swap
// [R17] per-event flags readable by software
// [R18] return restores flags, pops PC
// [R19] option register write-only, resets zero
// [R20] option bits: level 6, polarity 5, enable 4
// [R21] return lifts maskable inhibit
// [R22] reset clears latches, normal flags active
//
// The implementer's own choices: the plain strobed port and the register offsets.
`include "pirq_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module pirq_ctrl (
	input  wire                    clk,
	input  wire                    resetn,
	input  wire [`PIRQ_AW-1:0]     addr,
	input  wire [`PIRQ_DW-1:0]     wdata,
	input  wire                    wr_stb,
	input  wire                    rd_stb,
	output reg  [`PIRQ_DW-1:0]     rdata,
	input  wire                    nmi_n,
	input  wire [`PIRQ_NEVT-1:0]   src1_evt_n,
	input  wire [`PIRQ_NEVT-1:0]   src2_evt_n,
	input  wire [`PIRQ_NEVT-1:0]   src3_evt_n,
	input  wire [`PIRQ_NEVT-1:0]   src4_evt_n,
	input  wire                    instr_end,
	input  wire                    return_from_irq_instr,
	input  wire                    opt_ldi_zero,
	input  wire                    low_power,
	input  wire                    flag_we,
	input  wire                    carry_in,
	input  wire                    zero_in,
	output reg                     irq_take,
	output reg  [`PIRQ_VW-1:0]     irq_vector,
	output reg                     stack_push,
	output reg                     stack_pop,
	output wire                    carry_out,
	output wire                    zero_out,
	output wire                    wake,
	output wire [1:0]              irq_mode
);

	// synchronised pins
	wire                  nmi_s;
	wire [`PIRQ_NEVT-1:0] e1_s;
	wire [`PIRQ_NEVT-1:0] e2_s;
	wire [`PIRQ_NEVT-1:0] e3_s;
	wire [`PIRQ_NEVT-1:0] e4_s;

	pirq_sync #(.W(1 + 4 * `PIRQ_NEVT), .RST(1'b1)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    ({nmi_n, src1_evt_n, src2_evt_n, src3_evt_n, src4_evt_n}),
		.dout   ({nmi_s, e1_s, e2_s, e3_s, e4_s})
	);

	// [R17] events wired-or onto each line
	wire line1 = &e1_s;
	wire line2 = &e2_s;
	wire line3 = &e3_s;
	wire line4 = &e4_s;

	reg [`PIRQ_DW-1:0]     option_r;
	reg [1:0]              mode_r;
	reg [1:0]              mode_nxt;
	reg [1:0]              prev_mode_r;
	reg [1:0]              prev_mode_nxt;
	reg [1:0]              fsel_r;
	reg [1:0]              fsel_nxt;
	reg [1:0]              prev_fsel_r;
	reg [1:0]              prev_fsel_nxt;
	reg                    inhibit_r;
	reg                    inhibit_nxt;
	reg [1:0]              ldi_cnt_r;
	reg                    defect_r;
	reg [2:0]              carry_r;
	reg [2:0]              zero_r;
	reg [2*`PIRQ_NEVT-1:0] evt_a_r;
	reg [2*`PIRQ_NEVT-1:0] evt_b_r;

	// [R20] option fields
	wire level_edge_select = option_r[`PIRQ_BIT_LES];
	wire edge_polarity_select = option_r[`PIRQ_BIT_ESB];
	wire gen = option_r[`PIRQ_BIT_GEN];
	wire req_nmi;
	wire req1;
	wire req2;
	wire req3;
	wire req4;
	wire take_nmi;
	wire take_m;
	wire clr_nmi;
	wire clr1;
	wire clr2;
	// [R07] nmi falling edge latched
	pirq_edge_latch u_nmi (
		.clk        (clk),
		.resetn     (resetn),
		.line       (nmi_s),
		.level_mode (1'b0),
		.rise_sel   (1'b0),
		.clr        (clr_nmi),
		.req        (req_nmi)
	);

	// [R08] source 1 sense
	pirq_edge_latch u_src1 (
		.clk        (clk),
		.resetn     (resetn),
		.line       (line1),
		.level_mode (level_edge_select),
		.rise_sel   (1'b0),
		.clr        (clr1),
		.req        (req1)
	);
	// [R09] source 2 polarity
	pirq_edge_latch u_src2 (
		.clk        (clk),
		.resetn     (resetn),
		.line       (line2),
		.level_mode (1'b0),
		.rise_sel   (edge_polarity_select),
		.clr        (clr2),
		.req        (req2)
	);
	// [R10] level only sources
	assign req3 = ~line3;
	assign req4 = ~line4;

	function [`PIRQ_VW-1:0] vec_of;
		input r1;
		input r2;
		input r3;
		begin
			// [R04] fixed priority
			if (r1)
				vec_of = `PIRQ_VEC_SRC1;
			else if (r2)
				vec_of = `PIRQ_VEC_SRC2;
			else if (r3)
				vec_of = `PIRQ_VEC_SRC3;
			else
				vec_of = `PIRQ_VEC_SRC4;
		end
	endfunction

	wire m_any = req1 | req2 | req3 | req4;
	// [R05] enable gates maskables
	wire m_ok  = gen & m_any;
	// [R03] nmi preempts, maskables only from normal
	assign take_nmi = instr_end & req_nmi & (mode_r != `PIRQ_MODE_NMI);
	// [R13] sample at boundary
	assign take_m   = instr_end & ~take_nmi & m_ok & ~inhibit_r &
	                  (mode_r == `PIRQ_MODE_NORM);

	// [R15] first latch cleared on entry
	assign clr_nmi = take_nmi;
	assign clr1    = take_m & req1;
	assign clr2    = take_m & ~req1 & req2;
	// [R06] nmi wakes only with enable
	assign wake = low_power & gen & (req_nmi | m_any);

	// [R16] defect window tracking
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ldi_cnt_r <= 2'h0;
			defect_r  <= 1'b0;
		end else begin
			if (opt_ldi_zero)
				ldi_cnt_r <= `PIRQ_LDI_WIN;
			else if (ldi_cnt_r != 2'h0)
				ldi_cnt_r <= ldi_cnt_r - 2'h1;
			if ((opt_ldi_zero | (ldi_cnt_r != 2'h0)) & m_ok &
			    (mode_r == `PIRQ_MODE_NORM))
				defect_r <= 1'b1;
			else if (instr_end)
				defect_r <= 1'b0;
		end
	end

	// mode sequencing
	always @* begin
		mode_nxt      = mode_r;
		prev_mode_nxt = prev_mode_r;
		fsel_nxt      = fsel_r;
		prev_fsel_nxt = prev_fsel_r;
		inhibit_nxt   = inhibit_r;
		if (take_nmi) begin
			// [R14] nmi pair swapped in
			prev_mode_nxt = mode_r;
			prev_fsel_nxt = fsel_r;
			mode_nxt      = `PIRQ_MODE_NMI;
			fsel_nxt      = `PIRQ_MODE_NMI;
			inhibit_nxt   = 1'b1;
		end else if (take_m) begin
			mode_nxt    = `PIRQ_MODE_IRQ;
			inhibit_nxt = 1'b1;
			// [R16] swap skipped in window
			if (!defect_r)
				fsel_nxt = `PIRQ_MODE_IRQ;
		end else if (return_from_irq_instr) begin
			case (mode_r)
				`PIRQ_MODE_NMI: begin
					// [R18] restore previous set
					mode_nxt = prev_mode_r;
					fsel_nxt = prev_fsel_r;
				end
				`PIRQ_MODE_IRQ: begin
					mode_nxt = `PIRQ_MODE_NORM;
					fsel_nxt = `PIRQ_MODE_NORM;
				end
				default: mode_nxt = mode_r;
			endcase
			// [R21] inhibit lifted on return to normal mode
			if (mode_nxt == `PIRQ_MODE_NORM)
				inhibit_nxt = 1'b0;
		end
	end

	// [R22] reset to normal context
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_r      <= `PIRQ_MODE_NORM;
			prev_mode_r <= `PIRQ_MODE_NORM;
			fsel_r      <= `PIRQ_MODE_NORM;
			prev_fsel_r <= `PIRQ_MODE_NORM;
			inhibit_r   <= 1'b0;
		end else begin
			mode_r      <= mode_nxt;
			prev_mode_r <= prev_mode_nxt;
			fsel_r      <= fsel_nxt;
			prev_fsel_r <= prev_fsel_nxt;
			inhibit_r   <= inhibit_nxt;
		end
	end

	// [R15] push and vector on entry
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_take   <= 1'b0;
			stack_push <= 1'b0;
			stack_pop  <= 1'b0;
			irq_vector <= `PIRQ_VEC_NMI;
		end else begin
			irq_take   <= take_nmi | take_m;
			stack_push <= take_nmi | take_m;
			// [R18] pop saved PC
			stack_pop  <= return_from_irq_instr & ~take_nmi & ~take_m &
			              (mode_r != `PIRQ_MODE_NORM);
			// [R01] nmi own vector
			if (take_nmi)
				irq_vector <= `PIRQ_VEC_NMI;
			// [R02] maskable vector loaded
			else if (take_m)
				irq_vector <= vec_of(req1, req2, req3);
		end
	end

	// [R14] three flag pairs
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			carry_r <= 3'h0;
			zero_r  <= 3'h0;
		end else if (flag_we) begin
			carry_r[fsel_r] <= carry_in;
			zero_r[fsel_r]  <= zero_in;
		end
	end

	assign carry_out = carry_r[fsel_r];
	assign zero_out  = zero_r[fsel_r];
	assign irq_mode  = mode_r;

	// [R19] option register, word writes only
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			option_r <= `PIRQ_OPTION_RST;
		else if (wr_stb && addr == `PIRQ_OFF_OPTION)
			option_r <= wdata;
	end

	// [R17] sticky event flags, set beats clear
	wire wr_a = wr_stb && addr == `PIRQ_OFF_EVT_A;
	wire wr_b = wr_stb && addr == `PIRQ_OFF_EVT_B;
	wire [2*`PIRQ_NEVT-1:0] ev_a = ~{e2_s, e1_s};
	wire [2*`PIRQ_NEVT-1:0] ev_b = ~{e4_s, e3_s};

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			evt_a_r <= 8'h00;
			evt_b_r <= 8'h00;
		end else begin
			evt_a_r <= (evt_a_r & ~(wr_a ? wdata : 8'h00)) | ev_a;
			evt_b_r <= (evt_b_r & ~(wr_b ? wdata : 8'h00)) | ev_b;
		end
	end

	// read port, data one cycle after strobe
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata <= 8'h00;
		else if (rd_stb) begin
			case (addr)
				`PIRQ_OFF_EVT_A:
					rdata <= evt_a_r;
				`PIRQ_OFF_EVT_B:
					rdata <= evt_b_r;
				`PIRQ_OFF_STATUS:
					rdata <= {req_nmi, req1, req2, inhibit_r,
					          gen, defect_r, mode_r};
				default:
					rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

endmodule

`default_nettype wire

// ---- dv/pirq_core_model.sv ----
// core sequencer model: instruction boundaries and returns
`timescale 1ns/100ps
`default_nettype none

module pirq_core_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [3:0] gap,
	input  wire logic       ret_req,
	output logic            instr_end,
	output logic            ret_pulse
);
	logic [3:0] cnt_r;

	// return lands mid-instruction, never on a boundary while gap exceeds 1; with gap 1 it coincides with instr_end
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r     <= 4'h0;
			instr_end <= 1'b0;
			ret_pulse <= 1'b0;
		end else begin
			cnt_r     <= (cnt_r >= gap) ? 4'h0 : cnt_r + 4'h1;
			instr_end <= (cnt_r == gap);
			ret_pulse <= ret_req & (cnt_r == 4'h1);
		end
	end
endmodule

`default_nettype wire

// ---- dv/pirq_ctrl_properties.sv ----
// port checks for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`include "pirq_defines.vh"

module pirq_chk (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic [`PIRQ_AW-1:0] addr,
	input  wire logic                rd_stb,
	input  wire logic [`PIRQ_DW-1:0] rdata,
	input  wire logic                instr_end,
	input  wire logic                return_from_irq_instr,
	input  wire logic                low_power,
	input  wire logic                irq_take,
	input  wire logic [`PIRQ_VW-1:0] irq_vector,
	input  wire logic                stack_push,
	input  wire logic                stack_pop,
	input  wire logic                wake,
	input  wire logic [1:0]          irq_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_ret;
		return_from_irq_instr && irq_mode != `PIRQ_MODE_NORM;
	endsequence
	sequence s_irq_ret;
		s_ret ##0 (irq_mode == `PIRQ_MODE_IRQ && !instr_end);
	endsequence

	a_push_take: assert property (
		irq_take == stack_push)
		else $error("push and entry differ");
	a_take_bound: assert property (
		irq_take |-> $past(instr_end))
		else $error("entry off a boundary");
	a_nmi_vec: assert property (
		irq_take && irq_mode == `PIRQ_MODE_NMI
		|-> irq_vector == `PIRQ_VEC_NMI)
		else $error("bad nmi vector");
	a_mask_vec: assert property (
		irq_take && irq_mode == `PIRQ_MODE_IRQ |-> irq_vector inside
		{`PIRQ_VEC_SRC1, `PIRQ_VEC_SRC2, `PIRQ_VEC_SRC3, `PIRQ_VEC_SRC4})
		else $error("bad maskable vector");
	a_no_nest: assert property (
		irq_take && $past(irq_mode) != `PIRQ_MODE_NORM
		|-> irq_mode == `PIRQ_MODE_NMI)
		else $error("maskable entry nested");
	a_pop_ret: assert property (
		s_ret |=> stack_pop)
		else $error("no pop after return");
	a_mode_back: assert property (
		s_irq_ret |=> irq_mode == `PIRQ_MODE_NORM)
		else $error("mode not restored");
	a_wake_gate: assert property (
		wake |-> low_power)
		else $error("wake outside low power");
	a_opt_hidden: assert property (
		rd_stb && addr == `PIRQ_OFF_OPTION |=> rdata == 8'h00)
		else $error("option register readable");
endmodule

bind pirq_ctrl pirq_chk u_chk (.clk, .resetn, .addr, .rd_stb, .rdata,
	.instr_end, .return_from_irq_instr, .low_power, .irq_take,
	.irq_vector, .stack_push, .stack_pop, .wake, .irq_mode);

`default_nettype wire

// ---- dv/tb.sv ----
// bench for the interrupt controller with a core model
`timescale 1ns/100ps
`default_nettype none
`include "pirq_defines.vh"

module tb;
	logic        clk, resetn, wr_stb, rd_stb, nmi_n, rq, ie, rp;
	logic        lp, fw, ci, zi, take, rd_d, ldi, dfx, cout, zout, wk;
	logic [2:0]  cm, zm;
	logic [7:0]  addr, wdata, rdata;
	logic [15:0] ev_n;
	logic [11:0] vec;
	logic [3:0]  g;
	logic [1:0]  mode, fi, wk_en;
	logic [13:0] exp_q[$];
	logic [7:0]  rd_q[$];
	integer      n_mismatch, n_compared, cyc, seed, b, i;

	pirq_ctrl dut (
		.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .nmi_n(nmi_n),
		.src1_evt_n(ev_n[3:0]), .src2_evt_n(ev_n[7:4]),
		.src3_evt_n(ev_n[11:8]), .src4_evt_n(ev_n[15:12]),
		.instr_end(ie), .return_from_irq_instr(rp), .opt_ldi_zero(ldi),
		.low_power(lp), .flag_we(fw), .carry_in(ci), .zero_in(zi),
		.irq_take(take), .irq_vector(vec), .stack_push(),
		.stack_pop(), .carry_out(cout), .zero_out(zout), .wake(wk),
		.irq_mode(mode)
	);
	pirq_core_model u_core (.clk(clk), .resetn(resetn), .gap(g),
		.ret_req(rq), .instr_end(ie), .ret_pulse(rp));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task chk(input string what, input logic [13:0] e, input logic [13:0] s);
		n_compared = n_compared + 1;
		if (s !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR %s expected %h seen %h", what, e, s);
		end
	endtask

	task finish_test;
		chk("left", 14'h0, 14'(exp_q.size()));
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk) begin
		{lp, fw, ci, zi} <= 4'($random(seed));
		rd_d <= rd_stb;
		cyc = cyc + 1;
		if (take)
			chk("entry", exp_q.size() ? exp_q.pop_front() : 14'h3FFF,
				{mode, vec});
		if (rd_d)
			chk("rdata", {6'h0, rd_q.pop_front()}, {6'h0, rdata});
		if (wk_en != 2'h0)
			chk("wake", {13'h0, wk_en == 2'h2 && lp},
				{13'h0, wk});
		// active flag pair model, normal pair kept on a defect entry
		if (resetn) begin
			fi = (dfx && mode == 2'h1) ? 2'h0 : mode;
			chk("flags", {12'h0, cm[fi], zm[fi]},
				{12'h0, cout, zout});
			if (fw) begin
				cm[fi] = ci;
				zm[fi] = zi;
			end
		end
		if (cyc == 20000) begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
	end

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		rd_q.push_back(e);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
	endtask

	task serve(input logic [13:0] e);
		exp_q.push_back(e);
		repeat (60) if (exp_q.size()) @(posedge clk);
	endtask

	task ret(input logic [13:0] nx);
		if (nx != 14'h0)
			exp_q.push_back(nx);
		rq <= 1'b1;
		repeat (20) if (!rp) @(posedge clk);
		rq <= 1'b0;
		repeat (10) @(posedge clk);
		repeat (60) if (exp_q.size()) @(posedge clk);
	endtask

	initial begin
		seed = 32'h439a;
		n_mismatch = 0;
		n_compared = 0;
		cyc = 0;
		resetn = 1'b0;
		{wr_stb, rd_stb, rq, ldi, dfx, addr, wdata} = '0;
		{wk_en, cm, zm} = '0;
		nmi_n = 1'b1;
		ev_n = 16'hFFFF;
		g = 4'h3;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		rd(8'hC8, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'hF2, 8'h00);
		wr(8'hC8, 8'h50);
		rd(8'hF2, 8'h08);
		b = $random(seed) & 3;
		for (i = 0; i < 4; i++)
			ev_n[4*i+b] <= 1'b0;
		serve({2'h1, `PIRQ_VEC_SRC1});
		// next source pends unserved until the return
		for (i = 0; i < 4; i++) begin
			ev_n[4*i+b] <= 1'b1;
			repeat (8) @(posedge clk);
			ret(i < 3 ? {2'h1, 12'(12'hFF4 - 2*i)} : 14'h0);
		end
		wr(8'hC8, 8'h30);
		ev_n[0] <= 1'b0;
		serve({2'h1, `PIRQ_VEC_SRC1});
		repeat (2) begin
			ev_n[5] <= 1'b0;
			repeat (4) @(posedge clk);
			ev_n[5] <= 1'b1;
			repeat (4) @(posedge clk);
		end
		nmi_n <= 1'b0;
		serve({2'h2, `PIRQ_VEC_NMI});
		nmi_n <= 1'b1;
		ev_n[0] <= 1'b1;
		ret(14'h0);
		ret({2'h1, `PIRQ_VEC_SRC2});
		ret(14'h0);
		rd(8'hF0, 8'(8'h21 | (8'h11 << b)));
		wr(8'hF0, 8'hFF);
		rd(8'hF0, 8'h00);
		g = 4'hF;
		wr(8'hC8, 8'h00);
		wk_en = 2'h1;
		ev_n[8] <= 1'b0;
		repeat (40) @(posedge clk);
		nmi_n <= 1'b0;
		serve({2'h2, `PIRQ_VEC_NMI});
		wk_en = 2'h0;
		nmi_n <= 1'b1;
		ret(14'h0);
		wr(8'hC8, 8'h10);
		@(posedge clk);
		wk_en = 2'h2;
		serve({2'h1, `PIRQ_VEC_SRC3});
		wk_en = 2'h0;
		ev_n[8] <= 1'b1;
		ret(14'h0);
		// request inside the ldi zero window, right after a boundary
		while (!ie) @(posedge clk);
		ev_n[12] <= 1'b0;
		@(posedge clk);
		ldi <= 1'b1;
		@(posedge clk);
		ldi <= 1'b0;
		dfx = 1'b1;
		serve({2'h1, `PIRQ_VEC_SRC4});
		ev_n[12] <= 1'b1;
		ret(14'h0);
		dfx = 1'b0;
		repeat (40) @(posedge clk);
		finish_test;
	end
endmodule

`default_nettype wire
